// ---- dcs_top.sv ----
// Device control register and reset, lock and sync startup sequencer
`include "dcs_defs.svh"

module dcs_top #(
	parameter int RESET_CYCLES = `DCS_RESET_CYCLES,
	parameter int AUTO_SYNC_CYCLES = `DCS_AUTO_SYNC_CYCLES
) (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins
	input wire logic reset_pin_n,
	input wire logic sync_input_pin,
	// Register port
	input dcs_pkg::dcs_reg_wr_type reg_wr,
	input wire logic [7:0] reg_rd_addr,
	output logic [7:0] reg_rdata,
	// Configuration controller
	input wire logic cfg_done,
	input wire logic cfg_load,
	input wire logic [7:0] cfg_data,
	output logic cfg_start,
	// PLL
	input wire logic pll_locked,
	output logic pll_enable,
	// Outputs and clocks
	output logic out_enable,
	output logic out_mute,
	output logic sync_active,
	output logic sysclk_sel_vco,
	output logic aon_osc_enable,
	output logic func_reset_n
);

	localparam int RCW = $clog2(RESET_CYCLES + 1);
	localparam logic [RCW-1:0] RESET_LOAD = RCW'(RESET_CYCLES - 1);

	// ==========================================================
	// Declarations
	dcs_pkg::dcs_ctl_type ctl;
	dcs_pkg::dcs_ctl_type next_ctl;
	dcs_pkg::dcs_state_type state;
	dcs_pkg::dcs_state_type next_state;
	logic [7:0] next_ctl_raw;
	logic [7:0] next_rdata;
	logic [RCW-1:0] reset_cnt;
	logic [RCW-1:0] next_reset_cnt;
	logic cfg_needed;
	logic next_cfg_needed;
	logic ctl_hit;
	logic soft_reset_req;
	logic pin_reset_req;
	logic dev_reset_req;
	logic leave_reset;
	logic lock_done;
	logic auto_sync_pulse;
	logic sync_level;
	logic gen_next_active;
	logic next_sel_vco;
	logic in_reset;

	// ==========================================================
	// Register decode
	assign ctl_hit = reg_wr.wr && (reg_wr.addr == `DCS_DEVICE_CONTROL_ADDR);
	assign soft_reset_req = ctl_hit && !reg_wr.data[`DCS_BIT_SOFT_RESET_N];
	assign pin_reset_req = !reset_pin_n;
	assign dev_reset_req = soft_reset_req || pin_reset_req;
	// Host write wins over a configuration load in the same cycle
	assign next_ctl_raw = ctl_hit ? reg_wr.data :
		cfg_load ? ((ctl & ~`DCS_EEPROM_FIELD_MASK) | (cfg_data & `DCS_EEPROM_FIELD_MASK)) :
		ctl;
	// Soft reset bit returns to 1 and reserved bit 5 to 0 at once, the reset it requested leaves the other bits as written
	assign next_ctl = (next_ctl_raw | `DCS_SOFT_RESET_MASK) & ~`DCS_RESERVED_MASK;
	assign next_rdata = (reg_rd_addr == `DCS_DEVICE_CONTROL_ADDR) ? ctl : 8'h00;

	// Registers sit outside the function reset, only power-on clears them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= `DCS_DEVICE_CONTROL_RESET;
			reg_rdata <= 8'h00;
		end else begin
			ctl <= next_ctl;
			reg_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Startup sequencer
	assign in_reset = (state == dcs_pkg::ST_RESET);
	assign leave_reset = in_reset && (reset_cnt == '0) && !dev_reset_req;
	assign lock_done = (state == dcs_pkg::ST_LOCK) && pll_locked && !dev_reset_req;
	assign next_reset_cnt = dev_reset_req ? RESET_LOAD :
		(reset_cnt != '0) ? reset_cnt - RCW'(1) : '0;
	// Only power-on and the pin ask for a new configuration transfer
	assign next_cfg_needed = pin_reset_req ||
		(cfg_needed && !((state == dcs_pkg::ST_CONFIG) && cfg_done));

	always_comb begin
		next_state = state;
		case (state)
			dcs_pkg::ST_RESET: begin
				if (leave_reset) begin
					next_state = dcs_pkg::ST_CONFIG;
				end
			end
			dcs_pkg::ST_CONFIG: begin
				if (!cfg_needed || cfg_done) begin
					next_state = dcs_pkg::ST_HALT;
				end
			end
			dcs_pkg::ST_HALT: begin
				if (ctl.auto_lock_start) begin
					next_state = dcs_pkg::ST_LOCK;
				end
			end
			dcs_pkg::ST_LOCK: begin
				if (pll_locked) begin
					next_state = dcs_pkg::ST_RUN;
				end
			end
			dcs_pkg::ST_RUN: begin
				next_state = dcs_pkg::ST_RUN;
			end
			default: begin
				next_state = dcs_pkg::ST_RESET;
			end
		endcase
		if (dev_reset_req) begin
			next_state = dcs_pkg::ST_RESET;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= dcs_pkg::ST_RESET;
			reset_cnt <= RESET_LOAD;
			cfg_needed <= 1'b1;
		end else begin
			state <= next_state;
			reset_cnt <= next_reset_cnt;
			cfg_needed <= next_cfg_needed;
		end
	end

	// ==========================================================
	// Synchronization
	// Every lock reached is the first after a reset, so it counts as startup
	assign auto_sync_pulse = lock_done && ctl.sync_auto;
	assign sync_level = sync_input_pin || !ctl.soft_sync_n;

	dcs_sync_gen #(
		.AUTO_SYNC_CYCLES(AUTO_SYNC_CYCLES)
	) u_sync_gen (
		.clk(clk),
		.rst_n(rst_n),
		.clear(next_state == dcs_pkg::ST_RESET),
		.level_req(sync_level),
		.auto_pulse(auto_sync_pulse),
		.next_active(gen_next_active),
		.active(sync_active)
	);

	// ==========================================================
	// Output and clock control
	assign next_sel_vco = (next_state == dcs_pkg::ST_RUN) && pll_locked &&
		!ctl.keep_backup_clock_after_lock;

	// Oscillator stops only once the VCO clock has carried a full cycle,
	// and restarts on the same edge as the switch back so the system clock never stalls
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			func_reset_n <= 1'b0;
			cfg_start <= 1'b0;
			pll_enable <= 1'b0;
			out_enable <= 1'b0;
			out_mute <= 1'b0;
			sysclk_sel_vco <= 1'b0;
			aon_osc_enable <= 1'b1;
		end else begin
			func_reset_n <= (next_state != dcs_pkg::ST_RESET);
			cfg_start <= leave_reset && cfg_needed;
			pll_enable <= (next_state == dcs_pkg::ST_LOCK) || (next_state == dcs_pkg::ST_RUN);
			out_enable <= (next_state == dcs_pkg::ST_RUN);
			out_mute <= ctl.sync_mute && gen_next_active;
			sysclk_sel_vco <= next_sel_vco;
			aon_osc_enable <= !(sysclk_sel_vco && next_sel_vco);
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_lock_reached;
		(state == dcs_pkg::ST_LOCK) && pll_locked && !dev_reset_req;
	endsequence

	sequence s_soft_sync_written;
		ctl_hit && reg_wr.data[`DCS_BIT_SOFT_RESET_N] && !reg_wr.data[`DCS_BIT_SOFT_SYNC_N];
	endsequence

	property p_soft_reset;
		soft_reset_req |=> !func_reset_n && !out_enable && !pll_enable && ctl.soft_reset_n;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not reset");

	property p_no_reload;
		(soft_reset_req && !pin_reset_req && !cfg_needed) |=> !cfg_needed ##1 !cfg_start [*2];
	endproperty
	a_no_reload: assert property (p_no_reload) else $error("soft reset reran configuration");

	property p_sync_level;
		(sync_level && next_state != dcs_pkg::ST_RESET) |=> sync_active;
	endproperty
	a_sync_level: assert property (p_sync_level) else $error("sync request not seen");

	property p_auto_sync;
		(s_lock_reached and ctl.sync_auto) |=> sync_active && out_enable;
	endproperty
	a_auto_sync: assert property (p_auto_sync) else $error("startup sync missing");

	property p_mute;
		out_mute == ($past(ctl.sync_mute) && sync_active);
	endproperty
	a_mute: assert property (p_mute) else $error("mute does not follow sync");

	property p_aon_off;
		$rose(sysclk_sel_vco) ##1 sysclk_sel_vco |-> !aon_osc_enable;
	endproperty
	a_aon_off: assert property (p_aon_off) else $error("oscillator not disabled");

	property p_vco_switch;
		(next_state == dcs_pkg::ST_RUN && pll_locked && !ctl.keep_backup_clock_after_lock)
			|=> sysclk_sel_vco;
	endproperty
	a_vco_switch: assert property (p_vco_switch) else $error("no switch to VCO clock");

	property p_keep_aon;
		ctl.keep_backup_clock_after_lock |=> !sysclk_sel_vco && aon_osc_enable;
	endproperty
	a_keep_aon: assert property (p_keep_aon) else $error("backup clock left");

	property p_autostart;
		(state == dcs_pkg::ST_HALT && ctl.auto_lock_start && !dev_reset_req)
			|=> state == dcs_pkg::ST_LOCK && pll_enable;
	endproperty
	a_autostart: assert property (p_autostart) else $error("autostart did not lock");

	property p_pin_reset;
		pin_reset_req |=> !func_reset_n && cfg_needed && !out_enable;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored");

	property p_halt;
		(state == dcs_pkg::ST_HALT && !ctl.auto_lock_start && !dev_reset_req)
			|=> state == dcs_pkg::ST_HALT && !pll_enable;
	endproperty
	a_halt: assert property (p_halt) else $error("halt left without autostart");

	property p_soft_sync_level;
		s_soft_sync_written ##1 (next_state != dcs_pkg::ST_RESET) |=> sync_active;
	endproperty
	a_soft_sync_level: assert property (p_soft_sync_level) else $error("soft sync lost");

	property p_reg_read;
		(reg_rd_addr == `DCS_DEVICE_CONTROL_ADDR) |=> reg_rdata == $past(ctl);
	endproperty
	a_reg_read: assert property (p_reg_read) else $error("control readback wrong");

	property p_ctl_fixed;
		ctl.soft_reset_n && !ctl.reserved_5;
	endproperty
	a_ctl_fixed: assert property (p_ctl_fixed) else $error("fixed control bits wrong");

	property p_unmute;
		!ctl.sync_mute |=> !out_mute;
	endproperty
	a_unmute: assert property (p_unmute) else $error("outputs muted with mute off");

	property p_sync_clear;
		(next_state == dcs_pkg::ST_RESET) |=> !sync_active && !out_mute;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("sync left on in reset");

	property p_run_hold;
		(state == dcs_pkg::ST_RUN && !dev_reset_req)
			|=> state == dcs_pkg::ST_RUN && out_enable;
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("run state left");

	// Functions held in reset keep the backup oscillator as system clock
	property p_reset_quiet;
		!func_reset_n |-> !pll_enable && !out_enable && !sysclk_sel_vco && aon_osc_enable;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");

	property p_aon_needs_vco;
		!aon_osc_enable |-> sysclk_sel_vco;
	endproperty
	a_aon_needs_vco: assert property (p_aon_needs_vco) else $error("system clock stalled");

endmodule // dcs_top

// ---- dcs_defs.svh ----
// Offsets, field positions, reset values and timing counts of device control startup
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

// ==========================================================
// Register map
`define DCS_DEVICE_CONTROL_ADDR 8'h0C
`define DCS_DEVICE_CONTROL_RESET 8'hD9
`define DCS_EEPROM_FIELD_MASK 8'h1F
`define DCS_SOFT_RESET_MASK 8'h80
`define DCS_RESERVED_MASK 8'h20

// ==========================================================
// Field positions
`define DCS_BIT_SOFT_RESET_N 7
`define DCS_BIT_SOFT_SYNC_N 6
`define DCS_BIT_SYNC_AUTO 4
`define DCS_BIT_SYNC_MUTE 3
`define DCS_BIT_KEEP_BACKUP 2
`define DCS_BIT_AUTO_LOCK_START 0

// ==========================================================
// Timing counts in clock cycles
`define DCS_RESET_CYCLES 4
`define DCS_AUTO_SYNC_CYCLES 16

`endif

// ---- dcs_pkg.sv ----
// Types shared by the device control startup block
package dcs_pkg;

	// ==========================================================
	// Control register layout
	typedef struct packed {
		logic soft_reset_n;
		logic soft_sync_n;
		logic reserved_5;
		logic sync_auto;
		logic sync_mute;
		logic keep_backup_clock_after_lock;
		logic reserved_1;
		logic auto_lock_start;
	} dcs_ctl_type;

	// ==========================================================
	// Register write request
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} dcs_reg_wr_type;

	// ==========================================================
	// Startup sequence states
	typedef enum logic [4:0] {
		ST_RESET = 5'h01,
		ST_CONFIG = 5'h02,
		ST_HALT = 5'h04,
		ST_LOCK = 5'h08,
		ST_RUN = 5'h10
	} dcs_state_type;

endpackage

// ---- dcs_sync_gen.sv ----
// Synchronization window generator: level requests plus a timed automatic window
module dcs_sync_gen #(
	parameter int AUTO_SYNC_CYCLES = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Requests
	input wire logic clear,
	input wire logic level_req,
	input wire logic auto_pulse,
	// Window
	output logic next_active,
	output logic active
);

	localparam int CW = $clog2(AUTO_SYNC_CYCLES + 1);
	localparam logic [CW-1:0] AUTO_LOAD = CW'(AUTO_SYNC_CYCLES);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;

	// ==========================================================
	// Window counter
	assign next_cnt = clear ? '0 :
		auto_pulse ? AUTO_LOAD :
		(cnt != '0) ? cnt - CW'(1) : '0;
	// Level request holds the window open as long as it stays asserted and clear is low
	assign next_active = !clear && (level_req || next_cnt != '0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			active <= 1'b0;
		end else begin
			cnt <= next_cnt;
			active <= next_active;
		end
	end

endmodule // dcs_sync_gen

// ---- dcs_host_model.sv ----
// Host model driving the register port of the control block
module dcs_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output dcs_pkg::dcs_reg_wr_type reg_wr,
	output logic [7:0] reg_rd_addr,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle read address is unmapped, so stale data cannot pass a check
	initial begin
		reg_wr = '0;
		reg_rd_addr = 8'hFF;
	end

	// ==========================================================
	// Single byte access, held over exactly one taking edge
	task write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = {1'b1, a, d};
		@(negedge clk);
		reg_wr = '0;
	endtask

	task read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_rd_addr = a;
		@(negedge clk);
		d = reg_rdata;
		reg_rd_addr = 8'hFF;
	endtask
endmodule // dcs_host_model

// ---- dcs_top_bench.sv ----
// Self-checking bench of the device control startup block
module dcs_top_bench;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic rst_n, reset_pin_n, sync_input_pin, cfg_done, cfg_load;
	logic pll_locked = 1'b0;
	logic [7:0] cfg_data, rd, ctl_m, n;
	dcs_pkg::dcs_reg_wr_type reg_wr;
	logic [7:0] reg_rd_addr, reg_rdata;
	logic cfg_start, pll_enable, out_enable, out_mute, sync_active;
	logic sysclk_sel_vco, aon_osc_enable, func_reset_n;
	int err_total = 0;
	int checks = 0;
	int cfg_cnt = 0;
	logic [16:0] lfsr = 17'd75262;

	always #5 clk = ~clk;
	// Fast loop: lock one cycle after enable
	always @(negedge clk) pll_locked <= pll_enable;
	// Counted at the falling edge, where the pulse has settled
	always @(negedge clk) if (cfg_start) cfg_cnt++;

	dcs_top #(.RESET_CYCLES(2), .AUTO_SYNC_CYCLES(3)) dut (.clk(clk), .rst_n(rst_n),
		.reset_pin_n(reset_pin_n), .sync_input_pin(sync_input_pin), .reg_wr(reg_wr),
		.reg_rd_addr(reg_rd_addr), .reg_rdata(reg_rdata), .cfg_done(cfg_done),
		.cfg_load(cfg_load), .cfg_data(cfg_data), .cfg_start(cfg_start),
		.pll_locked(pll_locked), .pll_enable(pll_enable), .out_enable(out_enable),
		.out_mute(out_mute), .sync_active(sync_active), .sysclk_sel_vco(sysclk_sel_vco),
		.aon_osc_enable(aon_osc_enable), .func_reset_n(func_reset_n));
	dcs_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
		.reg_rdata(reg_rdata));

	// ==========================================================
	// Helpers
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
		return lfsr[7:0];
	endfunction
	function automatic logic [7:0] st();
		return {1'b0, pll_enable, out_enable, out_mute, sync_active, sysclk_sel_vco,
			aon_osc_enable, func_reset_n};
	endfunction
	// Expected outputs in the running state, with or without a sync
	function automatic logic [7:0] ex(input logic s);
		return {3'b011, s & ctl_m[3], s, ~ctl_m[2], ctl_m[2], 1'b1};
	endfunction
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task wait_run();
		for (int i = 0; i < 40 && out_enable !== 1'b1; i++) @(negedge clk);
		if (out_enable !== 1'b1) begin
			err_total++;
			stop_test();
		end
	endtask
	task cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// Model keeps bit 7 high and bit 5 clear
	task wr(input logic [7:0] d);
		ctl_m = (d | 8'h80) & 8'hDF;
		host.write_reg(8'h0C, d);
	endtask
	task rd_chk(input string nm);
		host.read_reg(8'h0C, rd);
		chk(nm, rd, ctl_m);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		reset_pin_n = 1'b1;
		sync_input_pin = 1'b0;
		cfg_done = 1'b1;
		cfg_load = 1'b0;
		cfg_data = 8'h00;
		ctl_m = 8'hD9;
		cyc(3);
		rst_n = 1'b1;
		wait_run();
		cyc(1);
		chk("startup", st(), ex(1));
		cyc(4);
		chk("sync end", st(), ex(0));
		rd_chk("ctl reset");
		host.read_reg(8'h0D, rd);
		chk("unmapped", rd, 8'h00);
		$display("test startup done");
		repeat (4) begin
			wr(rnd() | 8'hC1);
			cyc(1);
			rd_chk("ctl rand");
			chk("clock sel", st(), ex(0));
		end
		$display("test random done");
		wr((ctl_m & 8'hBF) | 8'h0C);
		cyc(2);
		chk("soft sync", st(), ex(1));
		cyc(4);
		chk("sync held", st(), ex(1));
		wr(ctl_m | 8'h40);
		cyc(2);
		chk("sync off", st(), ex(0));
		wr(ctl_m & 8'hF7);
		sync_input_pin = 1'b1;
		cyc(2);
		chk("pin sync", st(), ex(1));
		sync_input_pin = 1'b0;
		cyc(2);
		chk("pin off", st(), ex(0));
		$display("test sync done");
		n = 8'(cfg_cnt);
		wr(ctl_m & 8'h7F);
		cyc(1);
		chk("soft rst", st(), 8'h02);
		wait_run();
		cyc(1);
		chk("no cfg", 8'(cfg_cnt), n);
		rd_chk("ctl kept");
		$display("test soft reset done");
		wr(ctl_m & 8'hFE);
		reset_pin_n = 1'b0;
		cyc(1);
		reset_pin_n = 1'b1;
		cyc(8);
		chk("halt", st(), 8'h03);
		chk("pin cfg", 8'(cfg_cnt), n + 8'h01);
		wr(ctl_m | 8'h01);
		wait_run();
		cyc(5);
		chk("restart", st(), ex(0));
		$display("test autostart done");
		// Image load touches only the low five bits
		cfg_data = rnd();
		cfg_load = 1'b1;
		ctl_m = (ctl_m & 8'hE0) | (cfg_data & 8'h1F);
		cyc(1);
		cfg_load = 1'b0;
		rd_chk("cfg load");
		chk("cfg clock", st(), ex(0));
		$display("test config load done");
		stop_test();
	end
endmodule // dcs_top_bench
